/* src/dmr_top.v */
// ==========================================================================
// Mode register two/three decode and action block
// ==========================================================================
// Holds the capture of both configuration registers from mode-load
// commands, write latency, termination choice, self-refresh rate and
// retention, pattern readout, and the AXI4-Lite register slave.
// Assumes pins pass through dmr_cmd_decode; self_refresh_active comes from
// device logic on aclk.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`include "dmr_defs.vh"

// Overview of operation
// - Write termination applies during write bursts even with nominal off.
// - During write leveling only nominal termination; no dynamic switching.
// - Self-refresh with partial retention keeps only the chosen bank region.
// - Without self-refresh, regular refresh keeps all data under retention.
// - A3-A5 set write column delay: cycles from write to first data.
// - Write latency is whole cycles only; no half-cycle settings.
// - Total write delay is added delay plus column delay.
// - A9-A10 select the dynamic write termination setting.
// - Bit 7 clear gives normal single self-refresh rate.
// - Bit 7 set doubles internal self-refresh rate regardless of heat.
// - Pattern readout enabled returns the fixed pattern on reads.
// - Pattern readout disabled ignores pattern select bits A1-A0.
module dmr_top #(
  parameter REFI_CYC = `DMR_REFI_CYC,
  parameter [7:0] PATTERN = 8'h55,
  parameter BURST_CYC = `DMR_BURST_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Command and address pins
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [2:0] bank_sel,
  input wire [13:0] addr,
  input wire odt_pin,
  // Device state from the surrounding array logic
  input wire self_refresh_active,
  // Results toward the array and data path
  output reg [1:0] on_die_termination,
  output reg [1:0] rtt_wr_sel,
  output reg write_data_take,
  output reg selfrefresh_tick,
  output reg [7:0] bank_retain,
  output reg pattern_valid,
  output reg [7:0] pattern_data
);

  // Decoded command stream
  wire mode_load;
  wire write_cmd;
  wire read_cmd;
  wire [2:0] bank_q;
  wire [13:0] addr_q;
  wire odt_q;
  wire take_w;
  wire burst_active;

  // Configuration and software state
  reg [13:0] lr_cfg_r;
  reg [13:0] rp_cfg_r;
  reg [31:0] ctrl_r;
  reg [3:0] flags_r;
  reg [3:0] flags_nxt;
  reg [15:0] refcnt_r;
  reg [10:0] ref_div_r;

  // AXI slave state
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  // ========================================================================
  // Functions
  // ========================================================================
  // Write column delay in cycles from its three-bit code
  function [4:0] wcd_cycles;
    input [2:0] code;
    begin
      if (code > `DMR_WCD_MAXCODE) begin
        wcd_cycles = `DMR_WCD_BASE;
      end else begin
        wcd_cycles = `DMR_WCD_BASE + {2'h0, code};
      end
    end
  endfunction

  // Banks kept refreshed for a partial retention code
  function [7:0] retain_mask;
    input [2:0] code;
    begin
      case (code)
        3'h0: retain_mask = 8'hff;
        3'h1: retain_mask = 8'h0f;
        3'h2: retain_mask = 8'h03;
        3'h3: retain_mask = 8'h01;
        3'h4: retain_mask = 8'hfc;
        3'h5: retain_mask = 8'hf0;
        3'h6: retain_mask = 8'hc0;
        3'h7: retain_mask = 8'h80;
        default: retain_mask = 8'hff;
      endcase
    end
  endfunction

  // ========================================================================
  // Pin capture and write timing
  // ========================================================================
  dmr_cmd_decode u_dec (
    .aclk(aclk),
    .aresetn(aresetn),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .bank_sel(bank_sel),
    .addr(addr),
    .odt_pin(odt_pin),
    .mode_load(mode_load),
    .write_cmd(write_cmd),
    .read_cmd(read_cmd),
    .bank_q(bank_q),
    .addr_q(addr_q),
    .odt_q(odt_q)
  );

  wire [4:0] wcd = wcd_cycles(lr_cfg_r[`DMR_LR_WCD_MSB:`DMR_LR_WCD_LSB]);
  wire [4:0] acd = ctrl_r[`DMR_CTRL_ACD_MSB:`DMR_CTRL_ACD_LSB];
  // Total delay is the plain sum of the two settings
  wire [5:0] twd = {1'b0, acd} + {1'b0, wcd};

  dmr_wlat #(
    .BURST_CYC(BURST_CYC)
  ) u_wlat (
    .aclk(aclk),
    .aresetn(aresetn),
    .write_cmd(write_cmd),
    .total_delay(twd),
    .data_take(take_w),
    .burst_active(burst_active)
  );

  // ========================================================================
  // Mode-load capture of both configuration registers
  // ========================================================================
  // Bank bits select the target; the other two targets are not ours
  wire load_lr = mode_load && bank_q == 3'h2;
  wire load_rp = mode_load && bank_q == 3'h3;

  always @(posedge aclk) begin
    if (!aresetn) begin
      lr_cfg_r <= `DMR_LR_RST;
      rp_cfg_r <= `DMR_RP_RST;
    end else begin
      if (load_lr) begin
        lr_cfg_r <= addr_q;
      end
      if (load_rp) begin
        // Pattern select dropped when readout is off
        rp_cfg_r <= addr_q[`DMR_RP_EN] ? addr_q : 14'h0000;
      end
    end
  end

  // ========================================================================
  // Status flags: sticky, set wins over a clear in the same cycle
  // ========================================================================
  // Bank bit 2 low is part of both target decodes, so a stray high bit
  // never reaches the latency config and cannot be flagged there.
  wire bank_sel_bit2_w = 1'b0;

  wire wr_status = aw_got_r && w_got_r && !s_axi_bvalid
    && awaddr_r == `DMR_OFS_STATUS && wstrb_r[0];

  always @* begin
    flags_nxt = flags_r;
    if (wr_status) begin
      flags_nxt = flags_nxt & ~wdata_r[3:0];
    end
    // Reserved bits loaded as one are flagged, not obeyed
    if (load_lr && (bank_sel_bit2_w ||
        (addr_q & `DMR_LR_RSVD_MASK) != 14'h0000)) begin
      flags_nxt[`DMR_ST_LR_RSVD] = 1'b1;
    end
    // Same check for the pattern config
    if (load_rp && (addr_q & `DMR_RP_RSVD_MASK) != 14'h0000) begin
      flags_nxt[`DMR_ST_RP_RSVD] = 1'b1;
    end
    if (load_lr && addr_q[5:3] > `DMR_WCD_MAXCODE) begin
      flags_nxt[`DMR_ST_CWL_BAD] = 1'b1;
    end
    if (load_lr && addr_q[10:9] == `DMR_RTT_WR_RSVD) begin
      flags_nxt[`DMR_ST_RTT_BAD] = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ========================================================================
  // Termination choice
  // ========================================================================
  // Write value applies during a burst even if nominal is disabled, but
  // never while write leveling runs, where only nominal may act.
  always @(posedge aclk) begin
    if (!aresetn) begin
      on_die_termination <= `DMR_RTT_OFF;
      rtt_wr_sel <= 2'h0;
    end else begin
      rtt_wr_sel <= lr_cfg_r[`DMR_LR_RTT_MSB:`DMR_LR_RTT_LSB];
      if (ctrl_r[`DMR_CTRL_WLEV]) begin
        on_die_termination <= (odt_q && ctrl_r[`DMR_CTRL_NOMEN]) ?
          `DMR_RTT_NOM : `DMR_RTT_OFF;
      end else if (burst_active &&
          lr_cfg_r[`DMR_LR_RTT_MSB:`DMR_LR_RTT_LSB] != 2'h0) begin
        on_die_termination <= `DMR_RTT_WR;
      end else if (odt_q && ctrl_r[`DMR_CTRL_NOMEN]) begin
        on_die_termination <= `DMR_RTT_NOM;
      end else begin
        on_die_termination <= `DMR_RTT_OFF;
      end
    end
  end

  // ========================================================================
  // Self-refresh rate divider and bank retention
  // ========================================================================
  // Period halves when the hot rate bit is set, whatever the temperature
  wire [10:0] ref_period = lr_cfg_r[`DMR_LR_HOT] ?
    REFI_CYC[11:1] : REFI_CYC[10:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_div_r <= 11'h000;
      selfrefresh_tick <= 1'b0;
      refcnt_r <= 16'h0000;
      bank_retain <= 8'hff;
    end else begin
      selfrefresh_tick <= 1'b0;
      if (!self_refresh_active) begin
        // Outside self-refresh the controller refreshes; all banks held
        ref_div_r <= 11'h000;
        bank_retain <= 8'hff;
      end else begin
        bank_retain <= retain_mask(
          lr_cfg_r[`DMR_LR_PAR_MSB:`DMR_LR_PAR_LSB]);
        if (ref_div_r >= ref_period - 11'h001) begin
          ref_div_r <= 11'h000;
          selfrefresh_tick <= 1'b1;
          refcnt_r <= refcnt_r + 16'h0001;
        end else begin
          ref_div_r <= ref_div_r + 11'h001;
        end
      end
    end
  end

  // ========================================================================
  // Write data strobe and pattern readout
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      write_data_take <= 1'b0;
      pattern_valid <= 1'b0;
      pattern_data <= 8'h00;
    end else begin
      write_data_take <= take_w;
      pattern_valid <= read_cmd && rp_cfg_r[`DMR_RP_EN];
      if (read_cmd && rp_cfg_r[`DMR_RP_EN]) begin
        pattern_data <= PATTERN;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite write channel
  // ========================================================================
  // Address and data taken in either order; response follows both
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  wire wr_hit = awaddr_r == `DMR_OFS_CTRL || awaddr_r == `DMR_OFS_STATUS
    || awaddr_r == `DMR_OFS_LRCFG || awaddr_r == `DMR_OFS_RPCFG
    || awaddr_r == `DMR_OFS_REFCNT;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_r <= `DMR_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
        if (awaddr_r == `DMR_OFS_CTRL) begin
          if (wstrb_r[0]) ctrl_r[7:0] <= wdata_r[7:0] & 8'h1f;
          if (wstrb_r[1]) ctrl_r[15:8] <= wdata_r[15:8] & 8'h03;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  // ========================================================================
  // One read at a time; data comes one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case ({s_axi_araddr[7:2], 2'h0})
        `DMR_OFS_CTRL: s_axi_rdata <= ctrl_r;
        `DMR_OFS_LRCFG: s_axi_rdata <= {18'h00000, lr_cfg_r};
        `DMR_OFS_RPCFG: s_axi_rdata <= {18'h00000, rp_cfg_r};
        `DMR_OFS_STATUS: s_axi_rdata <= {19'h00000, twd[4:0], 4'h0,
          flags_r};
        `DMR_OFS_REFCNT: s_axi_rdata <= {16'h0000, refcnt_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* src/dmr_defs.vh */
// ==========================================================================
// Constants for the mode register two/three decode block
// ==========================================================================
// Holds register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from every design file of the block.
`ifndef DMR_DEFS_VH
`define DMR_DEFS_VH

// ==========================================================================
// Register offsets (byte addresses on the AXI4-Lite bus)
// ==========================================================================
`define DMR_OFS_CTRL 8'h00
`define DMR_OFS_LRCFG 8'h04
`define DMR_OFS_RPCFG 8'h08
`define DMR_OFS_STATUS 8'h0c
`define DMR_OFS_REFCNT 8'h10

// ==========================================================================
// Control register fields and reset value
// ==========================================================================
`define DMR_CTRL_ACD_LSB 0
`define DMR_CTRL_ACD_MSB 4
`define DMR_CTRL_WLEV 8
`define DMR_CTRL_NOMEN 9
`define DMR_CTRL_RST 32'h0000_0000

// ==========================================================================
// Status register fields (flags are write-one-to-clear)
// ==========================================================================
`define DMR_ST_LR_RSVD 0
`define DMR_ST_RP_RSVD 1
`define DMR_ST_CWL_BAD 2
`define DMR_ST_RTT_BAD 3
`define DMR_ST_TWD_LSB 8
`define DMR_ST_TWD_MSB 12

// ==========================================================================
// Latency/refresh config fields (address pin positions)
// ==========================================================================
`define DMR_LR_PAR_LSB 0
`define DMR_LR_PAR_MSB 2
`define DMR_LR_WCD_LSB 3
`define DMR_LR_WCD_MSB 5
`define DMR_LR_ASR 6
`define DMR_LR_HOT 7
`define DMR_LR_RTT_LSB 9
`define DMR_LR_RTT_MSB 10
`define DMR_LR_RSVD_MASK 14'h3900
`define DMR_RP_RSVD_MASK 14'h3ff8
`define DMR_RP_EN 2
`define DMR_LR_RST 14'h0000
`define DMR_RP_RST 14'h0000

// ==========================================================================
// Write column delay encoding and termination selections
// ==========================================================================
`define DMR_WCD_BASE 5'h05
`define DMR_WCD_MAXCODE 3'h4
`define DMR_RTT_OFF 2'h0
`define DMR_RTT_NOM 2'h1
`define DMR_RTT_WR 2'h2
`define DMR_RTT_WR_RSVD 2'h3

// ==========================================================================
// Timing: clock rate and normal refresh interval
// ==========================================================================
`define DMR_CLK_MHZ 100
`define DMR_REFI_NS 7800
`define DMR_REFI_CYC ((`DMR_REFI_NS * `DMR_CLK_MHZ) / 1000)
`define DMR_BURST_CYC 4

`endif

/* src/dmr_cmd_decode.v */
// ==========================================================================
// Command pin synchroniser and command decoder
// ==========================================================================
// Holds the two-flop capture of the command/address pins and the decode
// of mode-load, write and read commands into one-cycle pulses.
// Assumes pins arrive from outside the aclk domain.
`include "dmr_defs.vh"

module dmr_cmd_decode (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Command and address pins
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [2:0] bank_sel,
  input wire [13:0] addr,
  input wire odt_pin,
  // Decoded outputs
  output reg mode_load,
  output reg write_cmd,
  output reg read_cmd,
  output reg [2:0] bank_q,
  output reg [13:0] addr_q,
  output reg odt_q
);

  reg [21:0] meta_r;
  reg [21:0] sync_r;

  // ========================================================================
  // Two-flop synchroniser; only the second stage feeds the decoder
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 22'h3c0000;
      sync_r <= 22'h3c0000;
    end else begin
      meta_r <= {cs_n, ras_n, cas_n, we_n, odt_pin, bank_sel, addr};
      sync_r <= meta_r;
    end
  end

  // Decode registered so that command and fields line up in time
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_load <= 1'b0;
      write_cmd <= 1'b0;
      read_cmd <= 1'b0;
      bank_q <= 3'h0;
      addr_q <= 14'h0000;
      odt_q <= 1'b0;
    end else begin
      mode_load <= (sync_r[21:18] == 4'h0);
      write_cmd <= (sync_r[21:18] == 4'h4);
      read_cmd <= (sync_r[21:18] == 4'h5);
      bank_q <= sync_r[16:14];
      addr_q <= sync_r[13:0];
      odt_q <= sync_r[17];
    end
  end

endmodule

/* src/dmr_wlat.v */
// ==========================================================================
// Write latency timer
// ==========================================================================
// Holds the counter that marks when the first write data bit is taken and
// the window of the write burst that follows it.
// Assumes one write in flight; a new write restarts the count.
`include "dmr_defs.vh"

module dmr_wlat #(
  parameter BURST_CYC = `DMR_BURST_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Request
  input wire write_cmd,
  input wire [5:0] total_delay,
  // Results
  output reg data_take,
  output wire burst_active
);

  reg [5:0] cnt_r;
  reg busy_r;
  reg [3:0] burst_r;

  // ========================================================================
  // Count whole cycles only; there is no half-cycle setting
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 6'h00;
      busy_r <= 1'b0;
      data_take <= 1'b0;
      burst_r <= 4'h0;
    end else begin
      data_take <= 1'b0;
      if (write_cmd) begin
        // Delay counted from the command: added plus column delay
        cnt_r <= total_delay - 6'h01;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == 6'h01) begin
          data_take <= 1'b1;
          busy_r <= 1'b0;
          burst_r <= BURST_CYC[3:0];
        end
        cnt_r <= cnt_r - 6'h01;
      end
      if (!write_cmd && burst_r != 4'h0) begin
        burst_r <= burst_r - 4'h1;
      end
    end
  end

  assign burst_active = (burst_r != 4'h0);

endmodule

/* dv/dmr_ctl_model.sv */
// Controller model driving the command and address pins.
// Assumes the bench calls its tasks; one command at a time.
`include "dmr_defs.vh"
// ==========================================
// Command pin driver
module dmr_ctl_model (
  // Clock
  input wire aclk,
  // Command and address pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] bank_sel,
  output logic [13:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  int al = 0;
  int twd = 5;
  // Refresh interval this controller keeps; halved when a load sets bit 7, whatever the temperature
  int refi = `DMR_REFI_CYC;
  // Deselected until the first command
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank_sel = 3'h0;
    addr = 14'h0000;
  end
  // One-cycle command, then the bus shows the inverse so nothing stale
  task automatic issue(input [3:0] c, input [2:0] b, input [13:0] a);
    @(posedge aclk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bank_sel <= b;
    addr <= a;
    @(posedge aclk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    bank_sel <= ~b;
    addr <= ~a;
  endtask
  // Mode load with reserved bits and bank bit 2 held at zero
  task automatic load(input [1:0] b, input [13:0] a);
    logic [13:0] m;
    m = (b == 2'h2) ? `DMR_LR_RSVD_MASK : `DMR_RP_RSVD_MASK;
    issue(4'h0, {1'b0, b}, a & ~m);
    if (b == 2'h2) twd = al + `DMR_WCD_BASE + a[5:3];
    if (b == 2'h2) refi = a[7] ? `DMR_REFI_CYC / 2 : `DMR_REFI_CYC;
  endtask
  task automatic wr();
    issue(4'h4, 3'h0, 14'h0000);
  endtask
  task automatic rd();
    issue(4'h5, 3'h0, 14'h0000);
  endtask
endmodule

/* dv/dmr_top_monitor.sv */
// Checker on the ports of dmr_top.
// Assumes a single aclk domain; bound below.
// ==========================================
// Port checker
module dmr_top_monitor #(
  parameter [7:0] PATTERN = 8'h55
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Device results
  input wire self_refresh_active,
  input wire [1:0] on_die_termination,
  input wire [1:0] rtt_wr_sel,
  input wire write_data_take,
  input wire selfrefresh_tick,
  input wire [7:0] bank_retain,
  input wire pattern_valid,
  input wire [7:0] pattern_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Two quiet cycles allow for the registered mask
  AST_RETAIN_FULL: assert property (
    !$past(self_refresh_active) && !$past(self_refresh_active, 2)
    |-> bank_retain == 8'hff) else $error("retention mask not full");
  AST_TICK_IN_SR: assert property (
    selfrefresh_tick |-> $past(self_refresh_active) || self_refresh_active)
    else $error("refresh tick outside self-refresh");
  AST_TICK_PULSE: assert property (
    selfrefresh_tick |=> !selfrefresh_tick) else $error("tick too long");
  AST_PAT_DATA: assert property (
    pattern_valid |-> pattern_data == PATTERN) else $error("bad pattern");
  AST_TAKE_PULSE: assert property (
    write_data_take |=> !write_data_take) else $error("take too long");
  AST_RTT_OFF: assert property (
    rtt_wr_sel == 2'h0 && $past(rtt_wr_sel) == 2'h0
    |-> on_die_termination != 2'h2) else $error("write value while off");
  AST_AR_READY: assert property (
    s_axi_arready == !s_axi_rvalid) else $error("arready mismatch");
  AST_R_LAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule
bind dmr_top dmr_top_monitor #(.PATTERN(PATTERN)) mon (.*);

/* dv/dmr_top_test.sv */
// Bench for dmr_top: bus tasks plus pin traffic from the model.
// Assumes model and checker files are compiled before this one.
`include "dmr_defs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
// ==========================================
// Bench top
module dmr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic odt_pin = 0, self_refresh_active = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic cs_n, ras_n, cas_n, we_n, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, write_data_take;
  logic selfrefresh_tick, pattern_valid;
  logic [2:0] bank_sel;
  logic [13:0] addr;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, on_die_termination, rtt_wr_sel;
  logic [31:0] s_axi_rdata;
  logic [7:0] bank_retain, pattern_data;
  int mismatches = 0, checks = 0, cyc = 0, n, base;
  // Short refresh interval keeps self-refresh counts quick
  dmr_top #(.REFI_CYC(16)) uut (.*);
  dmr_ctl_model ctl (.*);
  // Clock of 10 ns
  initial begin
    forever #5 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axi_wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rdc(input [7:0] a, input [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
    `CHK(rd, e)
  endtask
  // Cycles from a write command until the first data is taken
  task automatic lat(output int k);
    ctl.wr();
    k = 0;
    while (write_data_take !== 1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic pw(output int k);
    k = 0;
    while (pattern_valid !== 1 && k < 20) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic ticks(output int k);
    k = 0;
    repeat (160) begin
      @(posedge aclk);
      if (selfrefresh_tick === 1) k++;
    end
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rdc(`DMR_OFS_CTRL, 32'h0);
    rdc(`DMR_OFS_STATUS, {19'h0, `DMR_WCD_BASE, 8'h00});
    rdc(8'h14, 32'h0);
    `CHK(resp, 2'h2)
    axi_wr(8'h14, 32'h1);
    `CHK(resp, 2'h2)
    $display("test reset done");
    axi_wr(`DMR_OFS_CTRL, 32'h2);
    ctl.al = 2;
    for (int c = 0; c < 5; c++) begin
      ctl.load(2, 14'(c << 3));
      lat(n);
      if (c == 0) base = n;
      `CHK(n - base, c)
      `CHK(n, ctl.twd + 4)
      rdc(`DMR_OFS_STATUS, 32'(ctl.twd) << 8);
    end
    $display("test latency done");
    ctl.load(2, 14'h0200);
    lat(n);
    repeat (2) @(posedge aclk);
    `CHK(on_die_termination, `DMR_RTT_WR)
    `CHK(rtt_wr_sel, 2'h1)
    axi_wr(`DMR_OFS_CTRL, 32'h302);
    odt_pin <= 1;
    lat(n);
    repeat (2) @(posedge aclk);
    `CHK(on_die_termination, `DMR_RTT_NOM)
    $display("test termination done");
    ctl.load(2, 14'h0001);
    self_refresh_active <= 1;
    repeat (8) @(posedge aclk);
    `CHK(bank_retain, 8'h0f)
    ticks(n);
    `CHK(n inside {[9:10]}, 1'b1)
    self_refresh_active <= 0;
    ctl.load(2, 14'h0081);
    repeat (8) @(posedge aclk);
    `CHK(bank_retain, 8'hff)
    self_refresh_active <= 1;
    ticks(n);
    `CHK(n inside {[19:20]}, 1'b1)
    self_refresh_active <= 0;
    $display("test self-refresh done");
    ctl.load(3, 14'h0004);
    ctl.rd();
    pw(n);
    `CHK(n < 20, 1'b1)
    `CHK(pattern_data, 8'h55)
    ctl.load(3, 14'h0003);
    repeat (6) @(posedge aclk);
    rdc(`DMR_OFS_RPCFG, 32'h0);
    ctl.rd();
    pw(n);
    `CHK(n, 20)
    $display("test pattern done");
    // Reserved A8 set on purpose: flagged, then cleared by write-one
    ctl.issue(4'h0, 3'h2, 14'h0100);
    repeat (6) @(posedge aclk);
    rdc(`DMR_OFS_STATUS, 32'h0000_0701);
    axi_wr(`DMR_OFS_STATUS, 32'h1);
    rdc(`DMR_OFS_STATUS, 32'h0000_0700);
    $display("test flags done");
    tally_and_finish();
  end
endmodule
